/* rtl/cgw_map.svh */
/*
 * Constants of the CANopen error-reporting block: bus offsets,
 * field positions, reset values, CAN identifiers and error codes.
 * Assumes inclusion by bare name from the rtl folder.
 */
`ifndef CGW_MAP_SVH
`define CGW_MAP_SVH

// apb register byte offsets
`define CGW_OFS_CTRL 12'h000
`define CGW_OFS_STAT 12'h004
`define CGW_OFS_HIST 12'h008
`define CGW_OFS_BPC 12'h00C

// ctrl fields and reset value
`define CGW_CTRL_NODE_HI 6
`define CGW_CTRL_RST 7'h01

// status field positions
`define CGW_ST_PAS 0
`define CGW_ST_BOFF 1
`define CGW_ST_INIT 2
`define CGW_ST_EST 3

// can identifier bases
`define CGW_ID_EMCY 11'h080
`define CGW_ID_SDO_RX 11'h600
`define CGW_ID_SDO_TX 11'h580

// sdo commands and objects
`define CGW_SDO_UPREQ 8'h40
`define CGW_SDO_UPRSP 8'h42
`define CGW_SDO_ABORT 8'h80
`define CGW_SDO_NOOBJ 32'h0602_0000
`define CGW_OBJ_CUR 16'h3100
`define CGW_OBJ_HIST 16'h1003

// backplane codes
`define CGW_BP_OVR 16'h4501
`define CGW_BP_PAS 16'h4503
`define CGW_BP_BOFF 16'h4504
`define CGW_BP_TXD 16'h4506
`define CGW_BP_INIT 16'hC507
`define CGW_BP_GRD 16'h4508

// emergency codes and error register values
`define CGW_EM_COMM 16'h8110
`define CGW_EM_PAS 16'h8120
`define CGW_EM_GRD 16'h8130
`define CGW_EM_FIRST 16'hFF01
`define CGW_EM_OUT 16'hFF02
`define CGW_EM_MORE 16'hFF03
`define CGW_EM_NONE 16'h0000
`define CGW_ER_COMM 8'h11
`define CGW_ER_MOD 8'h81
`define CGW_ER_NONE 8'h00
`define CGW_IDX_OVR 8'h01
`define CGW_IDX_TXD 8'h02

`endif

/* rtl/cgw_pkg.sv */
/*
 * Types shared by the error-reporting block.
 * Assumes cgw_map.svh supplies the numbers.
 */
`default_nettype none
package cgw_pkg;
    typedef enum logic [0:0] {
        CGW_TX_IDLE = 1'b0,
        CGW_TX_SEND = 1'b1
    } cgw_tx_e;
    typedef logic [63:0] cgw_frame_t;
endpackage
`default_nettype wire

/* rtl/cgw_emcy_pack.sv */
/*
 * Packs an emergency frame payload, byte 0 in bits 7:0.
 * Assumes the caller supplies code, error register and module bytes.
 */
`timescale 1ns/1ps
`default_nettype none
module cgw_emcy_pack
    import cgw_pkg::*;
(
    // frame fields
    input wire logic [15:0] code,
    input wire logic [7:0] err_reg,
    input wire logic [7:0] module_index_byte,
    input wire logic [31:0] diag,
    // payload
    output cgw_frame_t data
);
    // code low byte first, then register, index, high diag byte first
    assign data = {diag[7:0], diag[15:8], diag[23:16], diag[31:24],
                   module_index_byte, err_reg, code[15:8], code[7:0]};
endmodule
`default_nettype wire

/* rtl/cgw_sdo_srv.sv */
/*
 * Decodes an expedited upload request and builds the reply payload.
 * Assumes the caller checks the identifier and holds the diag table.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cgw_map.svh"
module cgw_sdo_srv
    import cgw_pkg::*;
#(
    parameter int NMOD = 14
) (
    // request
    input wire logic [63:0] req,
    // object contents
    input wire logic [NMOD-1:0][31:0] cur,
    input wire logic [31:0] hist,
    // answer
    output logic is_upload,
    output cgw_frame_t rsp
);
    logic [15:0] idx;
    logic [7:0] sub;
    logic [31:0] val;
    logic hit;
    assign idx = req[23:8];
    assign sub = req[31:24];
    assign is_upload = req[7:0] == `CGW_SDO_UPREQ;
    always_comb begin
        val = 32'h0000_0000;
        hit = 1'b0;
        if (idx == `CGW_OBJ_HIST && sub == 8'h01) begin
            val = hist;
            hit = 1'b1;
        end else if (idx == `CGW_OBJ_CUR && sub != 8'h00 && {24'h0, sub} <= NMOD) begin
            // stored active-high, served active-low
            val = ~cur[sub - 8'h01];
            hit = 1'b1;
        end
        if (hit) begin
            rsp = {val[7:0], val[15:8], val[23:16], val[31:24],
                   sub, idx, `CGW_SDO_UPRSP};
        end else begin
            rsp = {`CGW_SDO_NOOBJ, sub, idx, `CGW_SDO_ABORT};
        end
    end
endmodule
`default_nettype wire

/* rtl/cgw_err_report.sv */
/*
 * CANopen error reporting: backplane codes, emergency frames,
 * current-error and history objects, expedited upload service, APB.
 * Assumes all inputs synchronous to core_clk and a CAN transmit
 * queue that takes one frame per tx_valid/tx_ready handshake.
 */
// Design decisions made here: the APB interface to the registers and the register addresses.
//
// How it works
// - rx overrun: 4501h, emcy 8110h, 11h, index 1
// - error passive: 4503h, emcy 8120h, recessive
// - bus off: 4504h, disconnect, no emcy
// - tx drop: 4506h, emcy 8110h, 11h, index 2
// - init failure: C507h only
// - guarding loss: 4508h, emcy 8130h, 11h
// - module alarms FF01/FF02/FF03, 81h, history
// - emergency identifier is 80h plus node
// - emergency payload eight bytes, fixed order
// - emergency register byte equals error register
// - requests on 600h+node, answers 580h+node
// - upload 40h request, 42h reply echoing index
// - object 3100 subindex is position plus one
// - current error bits read active low
// - object 1003 subindex 1 gives last error
// - status bit 30 is bit 6 of diag_byte_high
// - can faults forwarded as backplane codes
// - two emergency states, frame per transition
`timescale 1ns/1ps
`default_nettype none
`include "cgw_map.svh"
module cgw_err_report
    import cgw_pkg::*;
#(
    parameter int NMOD = 14
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // can controller faults
    input wire logic can_rx_overrun,
    input wire logic can_err_passive,
    input wire logic can_bus_off,
    input wire logic can_tx_drop,
    input wire logic can_init_fail,
    input wire logic guard_lost,
    // can line control
    output logic can_recessive_only,
    output logic can_disconnect,
    // module alarm events
    input wire logic mod_valid,
    input wire logic mod_incoming,
    input wire logic [7:0] module_index_byte,
    input wire logic [31:0] mod_diag,
    output logic mod_ready,
    // received service frames
    input wire logic rx_valid,
    input wire logic [10:0] rx_id,
    input wire logic [63:0] rx_data,
    // outgoing frames
    output logic tx_valid,
    output logic [10:0] tx_id,
    output logic [3:0] tx_dlc,
    output logic [63:0] tx_data,
    input wire logic tx_ready,
    // backplane error reports
    output logic bp_valid,
    output logic [15:0] bp_code
);

    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [6:0] node;
        logic pas_q;
        logic boff_q;
        logic init_q;
        logic init_seen;
        logic boff;
        logic pas;
        logic [5:0] bpend;
        logic [15:0] last_bp;
        logic bp_valid;
        logic [15:0] bp_code;
        logic [3:0] cpend;
        logic mpend;
        logic [15:0] mcode;
        logic [7:0] merr;
        logic [7:0] midx;
        logic [31:0] mdiag;
        logic spend;
        logic [63:0] sdata;
        logic [7:0] err_reg;
        logic estate;
        logic [7:0] act;
        logic [31:0] hist;
        logic [NMOD-1:0][31:0] cur;
        cgw_tx_e txs;
        logic [10:0] tx_id;
        logic [63:0] tx_data;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } cgw_state_s;

    cgw_state_s s_r;
    cgw_state_s s_nxt;

    ////////////////////////////////////////////////////////////////////
    // frame builders
    cgw_frame_t em_data;
    cgw_frame_t sdo_rsp;
    logic sdo_up;
    logic [15:0] em_code;
    logic [7:0] em_idx;
    logic [1:0] em_sel;

    always_comb begin
        em_sel = 2'd0;
        for (int i = 3; i >= 0; i--) begin
            if (s_r.cpend[i]) begin
                em_sel = 2'(i);
            end
        end
        case (em_sel)
            2'd0: em_code = `CGW_EM_PAS;
            2'd1: em_code = `CGW_EM_COMM;
            2'd2: em_code = `CGW_EM_COMM;
            default: em_code = `CGW_EM_GRD;
        endcase
        case (em_sel)
            2'd1: em_idx = `CGW_IDX_OVR;
            2'd2: em_idx = `CGW_IDX_TXD;
            default: em_idx = 8'h00;
        endcase
    end

    cgw_emcy_pack u_emcy (
        .code(em_code),
        .err_reg(`CGW_ER_COMM),
        .module_index_byte(em_idx),
        .diag(32'h0000_0000),
        .data(em_data)
    );

    cgw_sdo_srv #(.NMOD(NMOD)) u_sdo (
        .req(rx_data),
        .cur(s_r.cur),
        .hist(s_r.hist),
        .is_upload(sdo_up),
        .rsp(sdo_rsp)
    );

    cgw_frame_t mod_frame;
    cgw_emcy_pack u_mpack (
        .code(s_r.mcode),
        .err_reg(s_r.merr),
        .module_index_byte(s_r.midx),
        .diag(s_r.mdiag),
        .data(mod_frame)
    );

    function automatic logic [15:0] bp_of(input int i);
        case (i)
            0: bp_of = `CGW_BP_OVR;
            1: bp_of = `CGW_BP_PAS;
            2: bp_of = `CGW_BP_BOFF;
            3: bp_of = `CGW_BP_TXD;
            4: bp_of = `CGW_BP_INIT;
            default: bp_of = `CGW_BP_GRD;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic apb_acc;
    logic [10:0] emcy_id;
    logic [10:0] sdo_id;
    logic [5:0] bp_ev;
    logic [3:0] em_ev;
    logic bp_done;

    assign apb_acc = psel && penable;
    assign emcy_id = `CGW_ID_EMCY + {4'h0, s_r.node};
    assign sdo_id = `CGW_ID_SDO_TX + {4'h0, s_r.node};

    always_comb begin
        s_nxt = s_r;
        bp_done = 1'b0;
        // fault detection, edge-triggered for levels
        s_nxt.pas_q = can_err_passive;
        s_nxt.boff_q = can_bus_off;
        s_nxt.init_q = can_init_fail;
        s_nxt.pas = can_err_passive;
        bp_ev = {guard_lost, can_init_fail && !s_r.init_q, can_tx_drop,
                 can_bus_off && !s_r.boff_q, can_err_passive && !s_r.pas_q,
                 can_rx_overrun};
        // bus off and init failure send no emergency frame
        em_ev = {guard_lost, can_tx_drop, can_rx_overrun,
                 can_err_passive && !s_r.pas_q};
        if (can_bus_off && !s_r.boff_q) begin
            s_nxt.boff = 1'b1;
        end
        if (can_init_fail) begin
            s_nxt.init_seen = 1'b1;
        end

        // backplane report, one per cycle, set wins over clear
        s_nxt.bp_valid = 1'b0;
        for (int i = 5; i >= 0; i--) begin
            if (s_r.bpend[i]) begin
                s_nxt.bp_code = bp_of(i);
            end
        end
        if (s_r.bpend != 6'h00) begin
            s_nxt.bp_valid = 1'b1;
            s_nxt.last_bp = s_nxt.bp_code;
            bp_done = 1'b1;
        end
        if (bp_done) begin
            s_nxt.bpend = s_r.bpend & (s_r.bpend - 6'h01);
        end
        s_nxt.bpend = s_nxt.bpend | bp_ev;

        // transmit handshake
        if (s_r.txs == CGW_TX_SEND && tx_ready) begin
            s_nxt.txs = CGW_TX_IDLE;
        end
        if (s_r.boff) begin
            // disconnected: nothing leaves until sys_rst
            s_nxt.txs = CGW_TX_IDLE;
        end else if (s_nxt.txs == CGW_TX_IDLE) begin
            if (s_r.cpend != 4'h0) begin
                s_nxt.txs = CGW_TX_SEND;
                s_nxt.tx_id = emcy_id;
                s_nxt.tx_data = em_data;
                s_nxt.err_reg = `CGW_ER_COMM;
                s_nxt.cpend[em_sel] = 1'b0;
            end else if (s_r.mpend) begin
                s_nxt.txs = CGW_TX_SEND;
                s_nxt.tx_id = emcy_id;
                s_nxt.tx_data = mod_frame;
                s_nxt.err_reg = s_r.merr;
                s_nxt.mpend = 1'b0;
            end else if (s_r.spend) begin
                s_nxt.txs = CGW_TX_SEND;
                s_nxt.tx_id = sdo_id;
                s_nxt.tx_data = s_r.sdata;
                s_nxt.spend = 1'b0;
            end
        end
        s_nxt.cpend = s_nxt.cpend | em_ev;

        // module alarms and the two-state emergency condition
        if (mod_valid && !s_r.mpend) begin
            s_nxt.mpend = 1'b1;
            s_nxt.midx = module_index_byte;
            s_nxt.mdiag = mod_diag;
            s_nxt.merr = `CGW_ER_MOD;
            if (module_index_byte < 8'(NMOD)) begin
                s_nxt.cur[module_index_byte] = mod_diag;
            end
            if (mod_incoming) begin
                s_nxt.act = s_r.act + 8'h01;
                s_nxt.estate = 1'b1;
                s_nxt.mcode = s_r.estate ? `CGW_EM_MORE : `CGW_EM_FIRST;
                s_nxt.hist = mod_diag;
            end else if (s_r.act > 8'h01) begin
                s_nxt.act = s_r.act - 8'h01;
                s_nxt.mcode = `CGW_EM_OUT;
                s_nxt.hist = mod_diag;
            end else begin
                // last error gone: back to error free, history untouched
                s_nxt.act = 8'h00;
                s_nxt.estate = 1'b0;
                s_nxt.mcode = `CGW_EM_NONE;
                s_nxt.merr = `CGW_ER_NONE;
                s_nxt.midx = 8'h00;
                s_nxt.mdiag = 32'h0000_0000;
            end
        end

        // service requests; a request arriving while one is queued is dropped
        if (rx_valid && !s_r.spend && sdo_up
            && rx_id == `CGW_ID_SDO_RX + {4'h0, s_r.node}) begin
            s_nxt.spend = 1'b1;
            s_nxt.sdata = sdo_rsp;
        end

        // apb: one wait state, write lands with pready
        s_nxt.pready = apb_acc && !s_r.pready;
        if (apb_acc && !s_r.pready) begin
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata = 32'h0000_0000;
            if (paddr == `CGW_OFS_CTRL) begin
                s_nxt.prdata = {25'h0, s_r.node};
            end else if (paddr == `CGW_OFS_STAT) begin
                s_nxt.prdata = {8'h00, s_r.act, s_r.err_reg, 4'h0, s_r.estate,
                                s_r.init_seen, s_r.boff, s_r.pas};
            end else if (paddr == `CGW_OFS_HIST) begin
                s_nxt.prdata = s_r.hist;
            end else if (paddr == `CGW_OFS_BPC) begin
                s_nxt.prdata = {16'h0000, s_r.last_bp};
            end else begin
                s_nxt.pslverr = 1'b1;
            end
        end
        if (apb_acc && s_r.pready && pwrite && paddr == `CGW_OFS_CTRL) begin
            s_nxt.node = pwdata[`CGW_CTRL_NODE_HI:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.node <= `CGW_CTRL_RST;
            s_r.txs <= CGW_TX_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pready = s_r.pready;
    assign prdata = s_r.prdata;
    assign pslverr = s_r.pslverr;
    assign can_recessive_only = s_r.pas;
    assign can_disconnect = s_r.boff;
    assign mod_ready = !s_r.mpend;
    assign tx_valid = s_r.txs == CGW_TX_SEND;
    assign tx_id = s_r.tx_id;
    assign tx_dlc = 4'h8;
    assign tx_data = s_r.tx_data;
    assign bp_valid = s_r.bp_valid;
    assign bp_code = s_r.bp_code;

endmodule
`default_nettype wire

/* testbench/cgw_err_report_props.sv */
/* Assertions on the ports of the error-reporting top.
   Assumes one clock domain, bound into every cgw_err_report. */
`timescale 1ns/1ps
`default_nettype none
module cgw_err_report_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // can faults and line control
    input wire logic can_rx_overrun,
    input wire logic can_err_passive,
    input wire logic can_bus_off,
    input wire logic can_init_fail,
    input wire logic can_recessive_only,
    input wire logic can_disconnect,
    // frames and reports
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [10:0] tx_id,
    input wire logic [3:0] tx_dlc,
    input wire logic [63:0] tx_data,
    input wire logic bp_valid,
    input wire logic [15:0] bp_code
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic emcy;
    // emergency ids sit below 100h, service replies above 500h
    assign emcy = tx_valid && tx_id[10:7] == 4'h1;
    ////////////////////////////////
    a_dlc_eight: assert property (tx_valid |-> tx_dlc == 4'h8)
        else $error("frame length wrong");
    a_id_base: assert property (tx_valid |-> tx_id[10:7] inside {4'h1, 4'hB})
        else $error("frame id base wrong");
    a_ovr_report: assert property (
        can_rx_overrun |-> ##[1:8] (bp_valid && bp_code == 16'h4501))
        else $error("overrun not reported");
    a_pas_recess: assert property (
        1'b1 |=> can_recessive_only == $past(can_err_passive))
        else $error("recessive mode wrong");
    a_boff_disc: assert property ($rose(can_bus_off) |=> can_disconnect)
        else $error("no disconnect");
    a_disc_sticky: assert property (can_disconnect |=> can_disconnect)
        else $error("disconnect dropped");
    a_init_code: assert property (
        $rose(can_init_fail) |-> ##[1:8] (bp_valid && bp_code == 16'hC507))
        else $error("init failure not reported");
    a_comm_frame: assert property (emcy && tx_data[15:0] == 16'h8110 |->
        tx_data[23:16] == 8'h11 && tx_data[63:32] == 32'h0 && tx_data[31:24] inside {1, 2})
        else $error("comm frame wrong");
    a_mod_reg: assert property (emcy && tx_data[15:8] == 8'hFF |-> tx_data[23:16] == 8'h81)
        else $error("module register wrong");
    a_clear_zero: assert property (emcy && tx_data[15:0] == 16'h0 |-> tx_data == 64'h0)
        else $error("clear frame not zero");
    a_apb_wait: assert property ((psel && !penable ##1 psel && penable) |=> pready)
        else $error("apb answer late");
    ////////////////////////////////
    c_mod_frame: cover property (emcy && tx_ready && tx_data[15:8] == 8'hFF);
    c_sdo_reply: cover property (tx_valid && tx_ready && tx_id[10:7] == 4'hB);
    c_disc: cover property ($rose(can_disconnect));
endmodule
bind cgw_err_report cgw_err_report_props u_props (.core_clk, .sys_rst, .psel, .penable,
    .pready, .can_rx_overrun, .can_err_passive, .can_bus_off, .can_init_fail,
    .can_recessive_only, .can_disconnect, .tx_valid, .tx_ready, .tx_id, .tx_dlc, .tx_data,
    .bp_valid, .bp_code);
`default_nettype wire

/* testbench/cgw_master_model.sv */
/* Far-side CAN master: sends expedited uploads, takes gateway frames.
   Assumes requests and frames move on rising core_clk. */
`timescale 1ns/1ps
`default_nettype none
module cgw_master_model (
    // clock and mode
    input wire logic core_clk,
    input wire logic slow,
    input wire logic [6:0] node,
    // gateway frames
    input wire logic tx_valid,
    input wire logic [10:0] tx_id,
    input wire logic [63:0] tx_data,
    output logic tx_ready = 1'b0,
    // service requests
    output logic rx_valid = 1'b0,
    output logic [10:0] rx_id = 11'h000,
    output logic [63:0] rx_data = 64'h0
);
    logic [63:0] req_q[$];
    logic [74:0] got_q[$];
    int tick = 0;
    ////////////////////////////////
    task automatic upload(input logic [15:0] idx, input logic [7:0] sub);
        req_q.push_back({32'h0, sub, idx, 8'h40});
    endtask
    ////////////////////////////////
    always @(posedge core_clk) begin
        tick <= tick + 1;
        // slow master takes a frame only every third cycle
        tx_ready <= !slow || tick % 3 == 2;
        if (tx_valid && tx_ready) begin
            got_q.push_back({tx_id, tx_data});
        end
        if (req_q.size() > 0) begin
            rx_valid <= 1'b1;
            rx_id <= 11'h600 + 11'(node);
            rx_data <= req_q.pop_front();
        end else begin
            // idle lines invert their last values every cycle rather than hold the last frame
            rx_valid <= 1'b0;
            rx_id <= ~rx_id;
            rx_data <= ~rx_data;
        end
    end
endmodule
`default_nettype wire

/* testbench/cgw_err_report_tb.sv */
/* Self-checking bench for the error-reporting block.
   Assumes checker and master model compile first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("unexpected %s expected %h seen %h", nm, e, g); \
    end \
end
module cgw_err_report_tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, err;
    logic can_bus_off = 1'b0, can_init_fail = 1'b0, mod_valid = 1'b0, mod_incoming = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, mod_diag = 32'h0, rd, hist, d, prdata;
    logic [3:0] ev = 4'h0;
    logic [7:0] module_index_byte = 8'h00;
    logic pready, pslverr, can_recessive_only, can_disconnect, mod_ready, tx_valid, tx_ready;
    logic rx_valid, bp_valid;
    logic [10:0] tx_id, rx_id;
    logic [3:0] tx_dlc;
    logic [63:0] tx_data, rx_data, ex;
    logic [15:0] bp_code, c;
    logic [31:0] cur[14];
    logic [15:0] bpc[4] = '{16'h4501, 16'h4503, 16'h4506, 16'h4508};
    logic [15:0] emc[4] = '{16'h8110, 16'h8120, 16'h8110, 16'h8130};
    logic [7:0] ixb[4] = '{8'h01, 8'h00, 8'h02, 8'h00};
    logic [7:0] pos[4] = '{8'h01, 8'h0C, 8'h01, 8'h0C};
    logic [3:0] inc = 4'h3;
    int fails = 0;
    int cmp_count = 0;
    int cnt, i;
    integer seed = 32'hF52040FC;
    cgw_err_report #(.NMOD(14)) dut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .can_rx_overrun(ev[0]), .can_err_passive(ev[1]),
        .can_bus_off, .can_tx_drop(ev[2]), .can_init_fail, .guard_lost(ev[3]),
        .can_recessive_only, .can_disconnect, .mod_valid, .mod_incoming, .module_index_byte,
        .mod_diag, .mod_ready, .rx_valid, .rx_id, .rx_data, .tx_valid, .tx_id, .tx_dlc,
        .tx_data, .tx_ready, .bp_valid, .bp_code);
    cgw_master_model mdl (.core_clk, .slow, .node(7'h0C), .tx_valid, .tx_id, .tx_data,
        .tx_ready, .rx_valid, .rx_id, .rx_data);
    always #5 core_clk = ~core_clk;
    ////////////////////////////////
    function automatic logic [63:0] frm(input logic [7:0] b0, b1, b2, b3,
        input logic [31:0] dg);
        return {dg[7:0], dg[15:8], dg[23:16], dg[31:24], b3, b2, b1, b0};
    endfunction
    function automatic logic [63:0] em(input logic [15:0] cd, input logic [7:0] er, ix,
        input logic [31:0] dg);
        return frm(cd[7:0], cd[15:8], er, ix, dg);
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic mod_evt(input logic in, input logic [7:0] p, input logic [31:0] dg);
        int n = 0;
        mod_valid <= 1'b1;
        mod_incoming <= in;
        module_index_byte <= p;
        mod_diag <= dg;
        @(posedge core_clk);
        while (mod_ready !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (mod_ready !== 1'b1) fails++;
        mod_valid <= 1'b0;
    endtask
    task automatic wait_bp(input logic [15:0] cd);
        int n = 0;
        while (bp_valid !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        `CHK("bp_valid", 1'b1, bp_valid)
        `CHK("bp_code", cd, bp_code)
    endtask
    task automatic wait_frame(input logic [10:0] id, input logic [63:0] dt);
        int n = 0;
        logic [74:0] f = 'x;
        while (mdl.got_q.size() == 0 && n < 99) begin
            @(posedge core_clk);
            n++;
        end
        if (mdl.got_q.size() > 0) f = mdl.got_q.pop_front();
        `CHK("frame", {id, dt}, f)
    endtask
    task automatic quiet();
        repeat (30) @(posedge core_clk);
        `CHK("frames", 0, mdl.got_q.size())
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////
    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        apb(1'b0, 12'h000, 32'h0);
        `CHK("ctrl", 32'h1, rd)
        apb(1'b0, 12'h008, 32'h0);
        `CHK("hist", 32'h0, rd)
        apb(1'b1, 12'h000, 32'h0C);
        apb(1'b0, 12'h000, 32'h0);
        `CHK("node", 32'h0C, rd)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {err, rd})
        for (i = 0; i < 4; i++) begin
            ev[i] <= 1'b1;
            @(posedge core_clk);
            ev <= ev & 4'h2;
            wait_bp(bpc[i]);
            wait_frame(11'h08C, em(emc[i], 8'h11, ixb[i], 32'h0));
        end
        `CHK("recessive", 1'b1, can_recessive_only)
        apb(1'b0, 12'h004, 32'h0);
        `CHK("status", {8'h11, 1'b1}, {rd[15:8], rd[0]})
        // slow master from here so module frames queue up
        slow <= 1'b1;
        cnt = 0;
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            if (i == 0) d[30] = 1'b1;
            mod_evt(inc[i], pos[i], d);
            cur[pos[i]] = d;
            if (inc[i]) begin
                c = (cnt == 0) ? 16'hFF01 : 16'hFF03;
                cnt++;
                hist = d;
            end else if (cnt > 1) begin
                c = 16'hFF02;
                cnt--;
                hist = d;
            end else begin
                c = 16'h0000;
                cnt = 0;
            end
            ex = (c == 16'h0) ? 64'h0 : em(c, 8'h81, pos[i], d);
            wait_frame(11'h08C, ex);
            apb(1'b0, 12'h004, 32'h0);
            `CHK("err_reg", c[15:8] & 8'h81, rd[15:8])
            apb(1'b0, 12'h008, 32'h0);
            `CHK("last_err", hist, rd)
        end
        mdl.upload(16'h1003, 8'h01);
        wait_frame(11'h58C, frm(8'h42, 8'h03, 8'h10, 8'h01, hist));
        for (i = 0; i < 2; i++) begin
            mdl.upload(16'h3100, pos[i] + 8'h01);
            wait_frame(11'h58C,
                frm(8'h42, 8'h00, 8'h31, pos[i] + 8'h01, ~cur[pos[i]]));
        end
        can_init_fail <= 1'b1;
        @(posedge core_clk);
        wait_bp(16'hC507);
        quiet();
        can_bus_off <= 1'b1;
        @(posedge core_clk);
        wait_bp(16'h4504);
        `CHK("disconnect", 1'b1, can_disconnect)
        ev[3] <= 1'b1;
        @(posedge core_clk);
        ev[3] <= 1'b0;
        wait_bp(16'h4508);
        quiet();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire
